/* hdl/nal_pkg.sv */
// Shared constants and types for the nibble ALU load/store datapath.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
package nal_pkg;
	// ==========================================
	// Widths and reset values
	localparam int NAL_W = 4;
	localparam int NAL_AW = 8;
	typedef logic [3:0] nal_nib_type;
	localparam nal_nib_type NAL_ZERO = 4'h0;
	localparam nal_nib_type NAL_ONE = 4'h1;
	localparam nal_nib_type NAL_ALL1 = 4'hF;
	localparam nal_nib_type NAL_WORK_RST = 4'h0;
	localparam nal_nib_type NAL_AUX_RST = 4'h0;
	localparam logic NAL_CF_RST = 1'b0;
	localparam logic NAL_ZF_RST = 1'b0;
	localparam logic [7:0] NAL_PTR_RST = 8'h00;
	localparam logic [7:0] NAL_PTR_ONE = 8'h01;

	// ==========================================
	// Opcode fields
	localparam logic [3:0] NAL_HI_LDI = 4'h8;
	localparam logic [3:0] NAL_HI_TWO = 4'hC;
	localparam logic [3:0] NAL_HI_EXT = 4'hF;
	localparam logic [3:0] NAL_EXT_ADDI = 4'h2;
	localparam logic [3:0] NAL_EXT_CMPI = 4'hA;
	localparam logic [3:0] NAL_EXT_CMPP = 4'hB;
	localparam logic [3:0] NAL_EXT_CMPB = 4'hD;
	localparam logic [3:0] NAL_DIR_INC = 4'h7;
	localparam logic [3:0] NAL_DIR_DEC = 4'h3;
	localparam logic [3:0] NAL_DIR_ADD = 4'h9;
	localparam logic [3:0] NAL_DIR_LOAD = 4'h1;
	localparam logic [3:0] NAL_DIR_SWAP = 4'h8;
	localparam logic [5:0] NAL_SETB_HI = 6'h03;
	localparam logic [5:0] NAL_CLRB_HI = 6'h0B;
	localparam logic [2:0] NAL_PTRF_HI = 3'h2;
	localparam logic [7:0] NAL_OPC_CLC = 8'h1E;
	localparam logic [7:0] NAL_OPC_STC = 8'h1F;
	localparam logic [7:0] NAL_OPC_INV = 8'h18;
	localparam logic [7:0] NAL_OPC_INCW = 8'h14;
	localparam logic [7:0] NAL_OPC_DECW = 8'h24;
	localparam logic [7:0] NAL_OPC_RRC = 8'h10;
	localparam logic [7:0] NAL_OPC_RLC = 8'h01;
	localparam logic [7:0] NAL_OPC_W2A = 8'h45;
	localparam logic [7:0] NAL_OPC_A2W = 8'h46;
	localparam logic [7:0] NAL_OPC_SWWA = 8'h44;
	localparam logic [7:0] NAL_OPC_INCM = 8'h12;
	localparam logic [7:0] NAL_OPC_DECM = 8'h22;
	localparam logic [7:0] NAL_OPC_ADD = 8'h06;
	localparam logic [7:0] NAL_OPC_ADC = 8'h02;
	localparam logic [7:0] NAL_OPC_SUBB = 8'h17;
	localparam logic [7:0] NAL_OPC_AND = 8'h07;
	localparam logic [7:0] NAL_OPC_OR = 8'h05;
	localparam logic [7:0] NAL_OPC_XOR = 8'h15;
	localparam logic [7:0] NAL_OPC_AND_TO_MEM = 8'h03;
	localparam logic [7:0] NAL_OPC_ORM = 8'h04;
	localparam logic [7:0] NAL_OPC_CMPM = 8'h16;
	localparam logic [7:0] NAL_OPC_LDP = 8'h5C;
	localparam logic [7:0] NAL_OPC_STP = 8'h5E;
	localparam logic [7:0] NAL_OPC_ST = 8'h47;

	// ==========================================
	// Operations, states, decoded instruction
	typedef enum logic [5:0] {
		NAL_OP_NOP, NAL_OP_LDI, NAL_OP_ADDI, NAL_OP_CLC, NAL_OP_STC, NAL_OP_INV,
		NAL_OP_INCW, NAL_OP_DECW, NAL_OP_RRC, NAL_OP_RLC, NAL_OP_W2A, NAL_OP_A2W,
		NAL_OP_SWWA, NAL_OP_INCM, NAL_OP_DECM, NAL_OP_SETB, NAL_OP_CLRB, NAL_OP_ADD,
		NAL_OP_ADC, NAL_OP_SUBB, NAL_OP_AND, NAL_OP_OR, NAL_OP_XOR, NAL_OP_AND_TO_MEM,
		NAL_OP_ORM, NAL_OP_CMPM, NAL_OP_CMPI, NAL_OP_CMPP, NAL_OP_CMPB, NAL_OP_LDP,
		NAL_OP_STP, NAL_OP_ST, NAL_OP_LDV, NAL_OP_SWV
	} nal_op_type;
	typedef enum logic [1:0] {
		NAL_ST_IDLE = 2'b00,
		NAL_ST_EXEC = 2'b01,
		NAL_ST_PAD1 = 2'b10,
		NAL_ST_PAD2 = 2'b11
	} nal_state_type;
	typedef struct packed {
		nal_op_type op;
		logic long_op;
		logic dir;
		logic sel_aux;
		logic step_en;
		logic step_dn;
		nal_nib_type imm;
		logic [1:0] bsel;
		logic [7:0] daddr;
	} nal_dec_type;
endpackage
`default_nettype wire

/* hdl/nal_mem_if.sv */
// Two-port nibble memory connection between datapath and its RAM.
// Assumes the RAM registers its read data on the shared clock.
`default_nettype none
interface nal_mem_if #(parameter int AW = 8);
	logic [AW-1:0] addr_a;
	logic [AW-1:0] addr_b;
	logic [3:0] wdata_a;
	logic [3:0] wdata_b;
	logic we_a;
	logic we_b;
	logic [3:0] rdata_a;
	logic [3:0] rdata_b;
	modport ctl (output addr_a, addr_b, wdata_a, wdata_b, we_a, we_b,
		input rdata_a, rdata_b);
	modport mem (input addr_a, addr_b, wdata_a, wdata_b, we_a, we_b,
		output rdata_a, rdata_b);
endinterface
`default_nettype wire

/* hdl/nal_nib_ram.sv */
// Dual-port nibble data memory with registered read data.
// Assumes the two ports never write the same address in one cycle.
`default_nettype none
module nal_nib_ram #(
	parameter int AW = 8
) (
	// Clock
	input wire logic clk_i,
	// Memory ports
	nal_mem_if.mem mp
);
	logic [3:0] mem_r [2**AW];

	if (AW < 1 || AW > 16) begin : g_bad_aw
		$error("nal_nib_ram: AW out of range");
	end

	// Read returns the old word on a same-cycle write
	always_ff @(posedge clk_i) begin
		mp.rdata_a <= mem_r[mp.addr_a];
		mp.rdata_b <= mem_r[mp.addr_b];
		if (mp.we_a) begin
			mem_r[mp.addr_a] <= mp.wdata_a;
		end
		if (mp.we_b) begin
			mem_r[mp.addr_b] <= mp.wdata_b;
		end
	end
endmodule // nal_nib_ram
`default_nettype wire

/* hdl/nal_core.sv */
// Nibble ALU with load/store of internal data memory, one op at a time.
// Assumes ops arrive as two bytes with valid/ready; one machine cycle is two clocks.
//
// What this block does
// - Clear instruction loads zero into working nibble and sets zero flag.
// - In a run of clear/load-immediate ops only the first one acts.
// - Decimal fixes add 6 or 10 as add-immediate, zero flag only.
// - Invert replaces working nibble with ones complement, zero flag updated.
// - Increment/decrement working nibble by one, update zero and carry.
// - Rotate right or left through carry; left also updates zero.
// - Copy working to aux, aux to working (zero flag), or swap both.
// - Increment/decrement memory at main pointer, write back, zero and carry.
// - Direct memory increment/decrement use 8-bit address, two cycles.
// - Set or clear chosen memory bit; only clear updates zero.
// - Add memory, pointer or direct, optionally with carry, to working nibble.
// - Add 4-bit immediate in two cycles, zero only, carry kept.
// - Memory minus working minus borrow; carry set means no borrow.
// - AND, OR, XOR memory into working nibble, zero flag updated.
// - AND, OR working nibble into memory, zero flag updated.
// - Memory compare adds complement plus one, sets carry and zero.
// - Immediate compare in two cycles sets zero and carry only.
// - Pointer compare sets zero when main pointer low equals immediate.
// - Bit compare sets zero when chosen working and memory bits match.
// - Pair load/store uses main pointer and next address; single store.
// - Pointer load/swap may post-step pointer low; zero follows the step.
// - Direct load and direct swap use an 8-bit address, two cycles.
`default_nettype none
module nal_core #(
	parameter int MEM_AW = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Instruction request
	input wire logic op_valid_i,
	input wire logic [7:0] op_byte0_i,
	input wire logic [7:0] op_byte1_i,
	output logic op_ready_o,
	output logic op_done_o,
	// Pointer load
	input wire logic ptr_wr_i,
	input wire logic ptr_sel_aux_i,
	input wire logic [7:0] ptr_val_i,
	// Memory preload
	input wire logic mem_wr_i,
	input wire logic [7:0] mem_addr_i,
	input wire logic [3:0] mem_data_i,
	// Visible state
	output logic [3:0] work_nibble_o,
	output logic [3:0] aux_nibble_o,
	output logic carry_flag_o,
	output logic zero_flag_o,
	output logic [7:0] main_ptr_o,
	output logic [7:0] aux_ptr_o
);
	import nal_pkg::*;

	if (MEM_AW != NAL_AW) begin : g_bad_aw
		$error("nal_core: MEM_AW must be 8");
	end

	// ==========================================
	// Helpers
	function automatic logic [4:0] nal_add(input nal_nib_type x, input nal_nib_type y,
		input logic c);
		return {1'b0, x} + {1'b0, y} + {4'h0, c};
	endfunction

	function automatic logic nal_zero(input nal_nib_type x);
		return x == NAL_ZERO;
	endfunction

	function automatic nal_nib_type nal_mask(input logic [1:0] t);
		return NAL_ONE << t;
	endfunction

	function automatic nal_dec_type nal_decode(input logic [7:0] b0, input logic [7:0] b1);
		nal_dec_type d;
		d = '0;
		d.imm = b0[3:0];
		d.bsel = b0[1:0];
		d.daddr = {b0[3:0], b1[3:0]};
		if (b0[7:4] == NAL_HI_LDI) begin
			d.op = NAL_OP_LDI;
		end else if (b0[7:4] == NAL_HI_TWO) begin
			d.long_op = 1'b1;
			d.imm = b1[3:0];
			d.bsel = b1[1:0];
			if (b1[7:4] == NAL_HI_EXT) begin
				case (b0[3:0])
					NAL_EXT_ADDI: d.op = NAL_OP_ADDI;
					NAL_EXT_CMPI: d.op = NAL_OP_CMPI;
					NAL_EXT_CMPP: d.op = NAL_OP_CMPP;
					NAL_EXT_CMPB: d.op = NAL_OP_CMPB;
					default: d.op = NAL_OP_NOP;
				endcase
			end else begin
				d.dir = 1'b1;
				case (b1[7:4])
					NAL_DIR_INC: d.op = NAL_OP_INCM;
					NAL_DIR_DEC: d.op = NAL_OP_DECM;
					NAL_DIR_ADD: d.op = NAL_OP_ADD;
					NAL_DIR_LOAD: d.op = NAL_OP_LDV;
					NAL_DIR_SWAP: d.op = NAL_OP_SWV;
					default: d.op = NAL_OP_NOP;
				endcase
			end
		end else if (b0[7:2] == NAL_SETB_HI) begin
			d.op = NAL_OP_SETB;
		end else if (b0[7:2] == NAL_CLRB_HI) begin
			d.op = NAL_OP_CLRB;
		end else if (b0[7:5] == NAL_PTRF_HI && b0[3] && (!b0[4] || b0[0])) begin
			d.op = b0[2] ? NAL_OP_SWV : NAL_OP_LDV;
			d.sel_aux = b0[1];
			d.step_en = b0[0];
			d.step_dn = b0[4];
			d.long_op = b0[0];
		end else begin
			case (b0)
				NAL_OPC_CLC: d.op = NAL_OP_CLC;
				NAL_OPC_STC: d.op = NAL_OP_STC;
				NAL_OPC_INV: d.op = NAL_OP_INV;
				NAL_OPC_INCW: d.op = NAL_OP_INCW;
				NAL_OPC_DECW: d.op = NAL_OP_DECW;
				NAL_OPC_RRC: d.op = NAL_OP_RRC;
				NAL_OPC_RLC: d.op = NAL_OP_RLC;
				NAL_OPC_W2A: d.op = NAL_OP_W2A;
				NAL_OPC_A2W: d.op = NAL_OP_A2W;
				NAL_OPC_SWWA: d.op = NAL_OP_SWWA;
				NAL_OPC_INCM: d.op = NAL_OP_INCM;
				NAL_OPC_DECM: d.op = NAL_OP_DECM;
				NAL_OPC_ADD: d.op = NAL_OP_ADD;
				NAL_OPC_ADC: d.op = NAL_OP_ADC;
				NAL_OPC_SUBB: d.op = NAL_OP_SUBB;
				NAL_OPC_AND: d.op = NAL_OP_AND;
				NAL_OPC_OR: d.op = NAL_OP_OR;
				NAL_OPC_XOR: d.op = NAL_OP_XOR;
				NAL_OPC_AND_TO_MEM: d.op = NAL_OP_AND_TO_MEM;
				NAL_OPC_ORM: d.op = NAL_OP_ORM;
				NAL_OPC_CMPM: d.op = NAL_OP_CMPM;
				NAL_OPC_LDP: d.op = NAL_OP_LDP;
				NAL_OPC_STP: d.op = NAL_OP_STP;
				NAL_OPC_ST: d.op = NAL_OP_ST;
				default: d.op = NAL_OP_NOP;
			endcase
		end
		return d;
	endfunction

	// ==========================================
	// State
	nal_state_type st_r;
	nal_dec_type dec_r, dec_in;
	nal_nib_type work_r, aux_r, work_nxt, aux_nxt, rd_a, rd_b, pl, pstep;
	logic cf_r, zf_r, cf_nxt, zf_nxt, last_ldi_r, ready_r, done_r;
	logic [7:0] main_ptr_r, aux_ptr_r, addr_a_r, addr_b_r;
	logic [4:0] sum;
	logic accept, exec, idle_side, we_a;
	nal_nib_type wdat_a;

	nal_mem_if #(.AW(NAL_AW)) mbus ();
	nal_nib_ram #(.AW(NAL_AW)) u_ram (
		.clk_i(clk_i),
		.mp(mbus.mem)
	);

	assign dec_in = nal_decode(op_byte0_i, op_byte1_i);
	assign accept = st_r == NAL_ST_IDLE && op_valid_i;
	assign exec = st_r == NAL_ST_EXEC;
	assign idle_side = st_r == NAL_ST_IDLE && !op_valid_i;
	assign rd_a = mbus.rdata_a;
	assign rd_b = mbus.rdata_b;
	assign pl = dec_r.sel_aux ? aux_ptr_r[3:0] : main_ptr_r[3:0];
	assign pstep = dec_r.step_dn ? pl - NAL_ONE : pl + NAL_ONE;

	// ==========================================
	// Sequencer: short op two clocks, long op four
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= NAL_ST_IDLE;
		end else begin
			unique case (st_r)
				NAL_ST_IDLE: st_r <= op_valid_i ? NAL_ST_EXEC : NAL_ST_IDLE;
				NAL_ST_EXEC: st_r <= dec_r.long_op ? NAL_ST_PAD1 : NAL_ST_IDLE;
				NAL_ST_PAD1: st_r <= NAL_ST_PAD2;
				NAL_ST_PAD2: st_r <= NAL_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ready_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			ready_r <= accept ? 1'b0 : (st_r == NAL_ST_IDLE || (exec && !dec_r.long_op)
				|| st_r == NAL_ST_PAD2);
			done_r <= (exec && !dec_r.long_op) || st_r == NAL_ST_PAD2;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dec_r <= '0;
			addr_a_r <= NAL_PTR_RST;
			addr_b_r <= NAL_PTR_RST;
		end else if (accept) begin
			dec_r <= dec_in;
			addr_a_r <= mbus.addr_a;
			addr_b_r <= mbus.addr_b;
		end
	end

	// ==========================================
	// Memory addressing and writes
	always_comb begin
		mbus.addr_a = addr_a_r;
		mbus.addr_b = addr_b_r;
		if (st_r == NAL_ST_IDLE) begin
			mbus.addr_a = dec_in.dir ? dec_in.daddr
				: (dec_in.sel_aux ? aux_ptr_r : main_ptr_r);
			mbus.addr_b = (mem_wr_i && !op_valid_i) ? mem_addr_i
				: 8'(main_ptr_r + NAL_PTR_ONE);
		end
		mbus.we_a = exec && we_a;
		mbus.wdata_a = wdat_a;
		mbus.we_b = (exec && dec_r.op == NAL_OP_STP) || (idle_side && mem_wr_i);
		mbus.wdata_b = exec ? aux_r : mem_data_i;
	end

	// ==========================================
	// ALU
	always_comb begin
		case (dec_r.op)
			NAL_OP_ADDI: sum = nal_add(work_r, dec_r.imm, 1'b0);
			NAL_OP_INCW: sum = nal_add(work_r, NAL_ONE, 1'b0);
			NAL_OP_DECW: sum = nal_add(work_r, NAL_ALL1, 1'b0);
			NAL_OP_INCM: sum = nal_add(rd_a, NAL_ONE, 1'b0);
			NAL_OP_DECM: sum = nal_add(rd_a, NAL_ALL1, 1'b0);
			NAL_OP_ADD: sum = nal_add(work_r, rd_a, 1'b0);
			NAL_OP_ADC: sum = nal_add(work_r, rd_a, cf_r);
			NAL_OP_SUBB: sum = nal_add(rd_a, ~work_r, cf_r);
			NAL_OP_CMPM: sum = nal_add(rd_a, ~work_r, 1'b1);
			NAL_OP_CMPI: sum = nal_add(dec_r.imm, ~work_r, 1'b1);
			default: sum = 5'h00;
		endcase
	end

	always_comb begin
		work_nxt = work_r;
		aux_nxt = aux_r;
		cf_nxt = cf_r;
		zf_nxt = zf_r;
		we_a = 1'b0;
		wdat_a = work_r;
		case (dec_r.op)
			NAL_OP_LDI: begin
				if (!last_ldi_r) begin
					work_nxt = dec_r.imm;
					zf_nxt = nal_zero(dec_r.imm);
				end
			end
			NAL_OP_ADDI: begin
				work_nxt = sum[3:0];
				zf_nxt = nal_zero(sum[3:0]);
			end
			NAL_OP_CLC: cf_nxt = 1'b0;
			NAL_OP_STC: cf_nxt = 1'b1;
			NAL_OP_INV: begin
				work_nxt = ~work_r;
				zf_nxt = nal_zero(~work_r);
			end
			NAL_OP_INCW, NAL_OP_DECW, NAL_OP_ADD, NAL_OP_ADC, NAL_OP_SUBB: begin
				work_nxt = sum[3:0];
				zf_nxt = nal_zero(sum[3:0]);
				cf_nxt = sum[4];
			end
			NAL_OP_RRC: begin
				work_nxt = {cf_r, work_r[3:1]};
				cf_nxt = work_r[0];
			end
			NAL_OP_RLC: begin
				work_nxt = {work_r[2:0], cf_r};
				cf_nxt = work_r[3];
				zf_nxt = nal_zero({work_r[2:0], cf_r});
			end
			NAL_OP_W2A: aux_nxt = work_r;
			NAL_OP_A2W: begin
				work_nxt = aux_r;
				zf_nxt = nal_zero(aux_r);
			end
			NAL_OP_SWWA: begin
				work_nxt = aux_r;
				aux_nxt = work_r;
			end
			NAL_OP_INCM, NAL_OP_DECM: begin
				we_a = 1'b1;
				wdat_a = sum[3:0];
				zf_nxt = nal_zero(sum[3:0]);
				cf_nxt = sum[4];
			end
			NAL_OP_SETB: begin
				we_a = 1'b1;
				wdat_a = rd_a | nal_mask(dec_r.bsel);
			end
			NAL_OP_CLRB: begin
				we_a = 1'b1;
				wdat_a = rd_a & ~nal_mask(dec_r.bsel);
				zf_nxt = nal_zero(rd_a & ~nal_mask(dec_r.bsel));
			end
			NAL_OP_AND: begin
				work_nxt = work_r & rd_a;
				zf_nxt = nal_zero(work_r & rd_a);
			end
			NAL_OP_OR: begin
				work_nxt = work_r | rd_a;
				zf_nxt = nal_zero(work_r | rd_a);
			end
			NAL_OP_XOR: begin
				work_nxt = work_r ^ rd_a;
				zf_nxt = nal_zero(work_r ^ rd_a);
			end
			NAL_OP_AND_TO_MEM: begin
				we_a = 1'b1;
				wdat_a = work_r & rd_a;
				zf_nxt = nal_zero(work_r & rd_a);
			end
			NAL_OP_ORM: begin
				we_a = 1'b1;
				wdat_a = work_r | rd_a;
				zf_nxt = nal_zero(work_r | rd_a);
			end
			NAL_OP_CMPM, NAL_OP_CMPI: begin
				zf_nxt = nal_zero(sum[3:0]);
				cf_nxt = sum[4];
			end
			NAL_OP_CMPP: zf_nxt = main_ptr_r[3:0] == dec_r.imm;
			NAL_OP_CMPB: zf_nxt = work_r[dec_r.bsel] == rd_a[dec_r.bsel];
			NAL_OP_LDP: begin
				work_nxt = rd_a;
				aux_nxt = rd_b;
			end
			NAL_OP_STP, NAL_OP_ST: we_a = 1'b1;
			NAL_OP_LDV: begin
				work_nxt = rd_a;
				zf_nxt = dec_r.step_en ? nal_zero(pstep) : nal_zero(rd_a);
			end
			NAL_OP_SWV: begin
				work_nxt = rd_a;
				we_a = 1'b1;
				if (dec_r.step_en) begin
					zf_nxt = nal_zero(pstep);
				end else if (!dec_r.dir) begin
					zf_nxt = nal_zero(rd_a);
				end
			end
			default: ;
		endcase
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			work_r <= NAL_WORK_RST;
			aux_r <= NAL_AUX_RST;
		end else if (exec) begin
			work_r <= work_nxt;
			aux_r <= aux_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cf_r <= NAL_CF_RST;
			zf_r <= NAL_ZF_RST;
		end else if (exec) begin
			cf_r <= cf_nxt;
			zf_r <= zf_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			last_ldi_r <= 1'b0;
		end else if (exec) begin
			last_ldi_r <= dec_r.op == NAL_OP_LDI;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			main_ptr_r <= NAL_PTR_RST;
			aux_ptr_r <= NAL_PTR_RST;
		end else if (idle_side && ptr_wr_i) begin
			if (ptr_sel_aux_i) begin
				aux_ptr_r <= ptr_val_i;
			end else begin
				main_ptr_r <= ptr_val_i;
			end
		end else if (exec && dec_r.step_en) begin
			if (dec_r.sel_aux) begin
				aux_ptr_r[3:0] <= pstep;
			end else begin
				main_ptr_r[3:0] <= pstep;
			end
		end
	end

	assign op_ready_o = ready_r;
	assign op_done_o = done_r;
	assign work_nibble_o = work_r;
	assign aux_nibble_o = aux_r;
	assign carry_flag_o = cf_r;
	assign zero_flag_o = zf_r;
	assign main_ptr_o = main_ptr_r;
	assign aux_ptr_o = aux_ptr_r;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_take_long;
		accept && dec_in.long_op;
	endsequence
	sequence s_long_run;
		st_r == NAL_ST_EXEC ##1 st_r == NAL_ST_PAD1 ##1 st_r == NAL_ST_PAD2 ##1 op_ready_o;
	endsequence

	clear_work_a: assert property (exec && dec_r.op == NAL_OP_LDI && !last_ldi_r |=>
		work_r == $past(dec_r.imm) && zf_r == ($past(dec_r.imm) == NAL_ZERO))
		else $error("load immediate result wrong");
	ldi_skip_a: assert property (exec && dec_r.op == NAL_OP_LDI && last_ldi_r |=>
		$stable(work_r) && $stable(zf_r)) else $error("repeated load not skipped");
	sum_imm_a: assert property (exec && dec_r.op == NAL_OP_ADDI |=>
		work_r == 4'($past(work_r) + $past(dec_r.imm)) && $stable(cf_r))
		else $error("add immediate wrong");
	invert_a: assert property (exec && dec_r.op == NAL_OP_INV |=>
		work_r == ~$past(work_r)) else $error("invert wrong");
	inc_work_a: assert property (exec && dec_r.op == NAL_OP_INCW |=>
		cf_r == ($past(work_r) == NAL_ALL1) && work_r == 4'($past(work_r) + NAL_ONE))
		else $error("increment wrong");
	rot_right_a: assert property (exec && dec_r.op == NAL_OP_RRC |=>
		cf_r == $past(work_r[0]) && work_r[3] == $past(cf_r) && $stable(zf_r))
		else $error("rotate right wrong");
	swap_aux_a: assert property (exec && dec_r.op == NAL_OP_SWWA |=>
		work_r == $past(aux_r) && aux_r == $past(work_r)) else $error("swap wrong");
	mem_inc_a: assert property (exec && dec_r.op == NAL_OP_INCM |->
		mbus.we_a && mbus.wdata_a == 4'(rd_a + NAL_ONE)
		##1 cf_r == ($past(rd_a) == NAL_ALL1) && zf_r == cf_r)
		else $error("memory increment wrong");
	long_timing_a: assert property (s_take_long |=> s_long_run)
		else $error("long op timing wrong");
	short_timing_a: assert property (accept && !dec_in.long_op |=> exec ##1 op_ready_o)
		else $error("short op timing wrong");
	ptr_cmp_a: assert property (exec && dec_r.op == NAL_OP_CMPP |=>
		zf_r == ($past(main_ptr_r[3:0]) == $past(dec_r.imm)) && $stable(work_r))
		else $error("pointer compare wrong");
	ptr_step_a: assert property (exec && dec_r.step_en && !dec_r.sel_aux && !dec_r.step_dn
		|=> main_ptr_r[3:0] == 4'($past(main_ptr_r[3:0]) + NAL_ONE)
		&& zf_r == (main_ptr_r[3:0] == NAL_ZERO)) else $error("pointer step wrong");
endmodule // nal_core
`default_nettype wire

/* bench/nal_core_bench.sv */
// Self-checking bench for the nibble ALU datapath, reference model inside.
// Assumes nal_core holds its own RAM; bench drives every port itself.
`default_nettype none
module nal_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import nal_pkg::*;
	// ==========================================
	// Signals and reference state
	logic clk_i = 1'h0, srst_i = 1'h1, op_valid_i = 1'h0, ptr_wr_i = 1'h0;
	logic ptr_sel_aux_i = 1'h0, mem_wr_i = 1'h0, op_ready_o, op_done_o;
	logic [7:0] op_byte0_i = 8'h00, op_byte1_i = 8'h00, ptr_val_i = 8'h00, mem_addr_i = 8'h00;
	logic [3:0] mem_data_i = 4'h0, work_nibble_o, aux_nibble_o;
	logic carry_flag_o, zero_flag_o, c, z, ldi;
	logic [7:0] main_ptr_o, aux_ptr_o, hp, xp;
	logic [26:0] seen;
	nal_nib_type w, a, mm [256];
	int n_errors = 0, total_checks = 0, cyc = 0;
	integer seed = 94847;
	localparam logic [7:0] tbl [47] = '{8'h1E, 8'h1F, 8'h18, 8'h14, 8'h24, 8'h10, 8'h01,
		8'h45, 8'h46, 8'h44, 8'h12, 8'h22, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h2C, 8'h2D, 8'h2E,
		8'h2F, 8'h06, 8'h02, 8'h17, 8'h07, 8'h05, 8'h15, 8'h03, 8'h04, 8'h16, 8'h5C, 8'h5E,
		8'h47, 8'h48, 8'h4A, 8'h49, 8'h4B, 8'h59, 8'h5B, 8'h4C, 8'h4E, 8'h4D, 8'h4F, 8'h5D,
		8'h5F, 8'h80, 8'hC0, 8'h58};
	localparam logic [3:0] dhi [5] = '{4'h7, 4'h3, 4'h9, 4'h1, 4'h8};
	localparam logic [3:0] elo [4] = '{4'h2, 4'hA, 4'hB, 4'hD};
	assign seen = {op_done_o, work_nibble_o, aux_nibble_o, carry_flag_o, zero_flag_o,
		main_ptr_o, aux_ptr_o};
	nal_core #(.MEM_AW(8)) dut (.clk_i, .srst_i, .op_valid_i, .op_byte0_i, .op_byte1_i,
		.op_ready_o, .op_done_o, .ptr_wr_i, .ptr_sel_aux_i, .ptr_val_i, .mem_wr_i,
		.mem_addr_i, .mem_data_i, .work_nibble_o, .aux_nibble_o, .carry_flag_o,
		.zero_flag_o, .main_ptr_o, .aux_ptr_o);
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			test_done();
		end
	end
	// ==========================================
	// Tasks
	task automatic chk(input logic [26:0] sv, ev);
		total_checks++;
		if (sv !== ev) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, sv, ev);
		end
	endtask
	task automatic test_done;
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic setw(input nal_nib_type v);
		w = v;
		z = (v == 4'h0);
	endtask
	task automatic setp(input logic sel, input logic [7:0] v);
		@(negedge clk_i);
		ptr_wr_i = 1'h1;
		ptr_sel_aux_i = sel;
		ptr_val_i = v;
		@(negedge clk_i);
		ptr_wr_i = 1'h0;
		if (sel) xp = v;
		else hp = v;
	endtask
	task automatic model(input logic [7:0] b0, b1);
		logic [4:0] s;
		logic [7:0] ad, p;
		nal_nib_type t, mv, n;
		ad = {b0[3:0], b1[3:0]};
		p = b0[1] ? xp : hp;
		mv = mm[hp];
		t = ~w;
		if (b0[7:4] == 4'h8) begin
			if (!ldi) setw(b0[3:0]);
			ldi = 1'h1;
			return;
		end
		ldi = 1'h0;
		case (b0)
			8'h1E, 8'h1F: c = b0[0];
			8'h18: setw(t);
			8'h14, 8'h24: begin s = w + (b0[5] ? 4'hF : 4'h1); c = s[4]; setw(s[3:0]); end
			8'h10: {w, c} = {c, w};
			8'h01: begin {c, w} = {w, c}; z = (w == 4'h0); end
			8'h45: a = w;
			8'h46: setw(a);
			8'h44: {w, a} = {a, w};
			8'h12, 8'h22: begin
				s = mv + (b0[5] ? 4'hF : 4'h1);
				c = s[4];
				mm[hp] = s[3:0];
				z = (s[3:0] == 4'h0);
			end
			8'h0C, 8'h0D, 8'h0E, 8'h0F: mm[hp][b0[1:0]] = 1'h1;
			8'h2C, 8'h2D, 8'h2E, 8'h2F: begin mm[hp][b0[1:0]] = 1'h0; z = (mm[hp] == 4'h0); end
			8'h06, 8'h02: begin s = w + mv + (b0[2] ? 1'h0 : c); c = s[4]; setw(s[3:0]); end
			8'h17, 8'h16: begin
				s = mv + t + (b0[0] ? c : 1'h1);
				c = s[4];
				if (b0[0]) setw(s[3:0]);
				else z = (s[3:0] == 4'h0);
			end
			8'h07: setw(w & mv);
			8'h05: setw(w | mv);
			8'h15: setw(w ^ mv);
			8'h03, 8'h04: begin mm[hp] = b0[0] ? (w & mv) : (w | mv); z = (mm[hp] == 4'h0); end
			8'h5C: begin w = mv; a = mm[hp + 8'h01]; end
			8'h5E: begin mm[hp] = w; mm[hp + 8'h01] = a; end
			8'h47: mm[hp] = w;
			8'h48, 8'h4A, 8'h49, 8'h4B, 8'h59, 8'h5B, 8'h4C, 8'h4E, 8'h4D, 8'h4F, 8'h5D, 8'h5F: begin
				n = mm[p];
				if (b0[2]) mm[p] = w;
				setw(n);
				if (b0[0]) begin
					n = p[3:0] + (b0[4] ? 4'hF : 4'h1);
					if (b0[1]) xp[3:0] = n;
					else hp[3:0] = n;
					z = (n == 4'h0);
				end
			end
			default: if (b0[7:4] == 4'hC) begin
				if (b1[7:4] == 4'hF) case (b0[3:0])
					4'h2: setw(w + b1[3:0]);
					4'hA: begin s = b1[3:0] + t + 5'h01; c = s[4]; z = (s[3:0] == 4'h0); end
					4'hB: z = (hp[3:0] == b1[3:0]);
					4'hD: z = (w[b1[1:0]] == mv[b1[1:0]]);
					default: ;
				endcase
				else case (b1[7:4])
					4'h7, 4'h3: begin
						s = mm[ad] + (b1[6] ? 4'h1 : 4'hF);
						c = s[4];
						mm[ad] = s[3:0];
						z = (s[3:0] == 4'h0);
					end
					4'h9: begin s = w + mm[ad]; c = s[4]; setw(s[3:0]); end
					4'h1: setw(mm[ad]);
					4'h8: {w, mm[ad]} = {mm[ad], w};
					default: ;
				endcase
			end
		endcase
	endtask
	task automatic op(input logic [7:0] b0, b1);
		int k;
		logic lg;
		k = 0;
		// Two-byte codes and pointer post-step variants take two machine cycles
		lg = b0[7:4] == 4'hC || (b0[7:5] == 3'h2 && b0[3] && b0[0]);
		@(negedge clk_i);
		while (op_ready_o !== 1'h1 && k < 8) begin @(negedge clk_i); k++; end
		op_byte0_i = b0;
		op_byte1_i = b1;
		op_valid_i = 1'h1;
		@(negedge clk_i);
		op_valid_i = 1'h0;
		chk(27'(op_ready_o), 27'h0);
		model(b0, b1);
		k = 0;
		while (op_done_o !== 1'h1 && k < 8) begin @(negedge clk_i); k++; end
		chk(seen, {1'h1, w, a, c, z, hp, xp});
		chk({op_ready_o, 26'(k)}, {1'h1, lg ? 26'h3 : 26'h1});
	endtask
	task automatic run(input logic [7:0] code);
		logic [7:0] b0, b1;
		logic [3:0] r, q;
		int k;
		r = 4'($random(seed));
		q = 4'($random(seed));
		k = $unsigned($random(seed)) % 9;
		b0 = code;
		b1 = {4'hF, r};
		if (code == 8'h80) b0 = {4'h8, r};
		if (code == 8'hC0 && k < 4) b0 = {4'hC, elo[k]};
		if (code == 8'hC0 && k >= 4) begin
			b0 = q[0] ? {4'hC, hp[7:4]} : {4'hC, q};
			b1 = q[0] ? {dhi[k-4], hp[3:0]} : {dhi[k-4], r};
		end
		if (code == 8'h5C || code == 8'h5E) setp(1'h0, {hp[7:1], 1'h0});
		op(b0, b1);
		op({4'hC, hp[7:4]}, {4'h1, hp[3:0]});
	endtask
	// ==========================================
	// Main sequence
	initial begin
		w = 4'h0; a = 4'h0; c = 1'h0; z = 1'h0; ldi = 1'h0; hp = 8'h00; xp = 8'h00;
		repeat (16) @(negedge clk_i);
		srst_i = 1'h0;
		for (int i = 0; i < 256; i++) begin
			@(negedge clk_i);
			mem_wr_i = 1'h1;
			mem_addr_i = 8'(i);
			mem_data_i = 4'($random(seed));
			mm[i] = mem_data_i;
		end
		@(negedge clk_i);
		mem_wr_i = 1'h0;
		setp(1'h0, 8'h3F);
		setp(1'h1, 8'hA0);
		op(8'h85, 8'h00);
		op(8'h8A, 8'h00);
		op(8'h80, 8'h00);
		foreach (tbl[i]) run(tbl[i]);
		for (int i = 0; i < 600; i++) begin
			if (i % 16 == 0) begin
				setp(1'h0, 8'($random(seed)));
				setp(1'h1, 8'($random(seed)));
			end
			run(tbl[$unsigned($random(seed)) % 47]);
		end
		test_done();
	end
endmodule // nal_core_bench
`default_nettype wire
